// File: dv/gpc_pad_model.sv
// board side of the seven pads: pull-ups plus optional external drivers
// assumes the group samples pin_in on hclk through its two-stage synchroniser
module gpc_pad_model (
  input wire logic [6:0] pin_out,
  input wire logic [6:0] pin_oe,
  input wire logic [6:0] ext_en,
  input wire logic [6:0] ext_val,
  output logic [6:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // a released pad takes ext_val when ext_en is set, else floats to the pull-up; never keeps the stale level
  always_comb begin
    for (int i = 0; i < 7; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
  end
endmodule

// File: dv/gpc_pin_group_tb.sv
// testbench for the pin configuration group over ahb-lite
// assumes a zero-wait slave; gpc_pad_model closes the pad loop
module gpc_pin_group_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] TCFG [8] = '{8'h04, 8'h04, 8'h00, 8'h06, 8'h0c, 8'h84, 8'h84, 8'h05};
  localparam logic [7:0] TSRC = 8'hdd;
  localparam logic [4:0] TOUT [8] = '{5'h1f, 5'h00, 5'h00, 5'h00, 5'h17, 5'h00, 5'h00, 5'h00};
  localparam logic [4:0] TOE [8] = '{5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h00, 5'h00};
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, src = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  logic hreadyout, hresp, ring_n, wr_en, irq;
  logic [6:0] pin_in, pin_out, pin_oe, pin_val, ext_en = 7'h00, ext_val = 7'h00, gpo = 7'h00;
  int err_count = 0, num_checks = 0, cyc = 0;
  always #25 hclk = ~hclk;
  gpc_pin_group u_gpc_pin_group (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_val(pin_val), .gpio_out_val(gpo), .keyboard_reset_out_n(src),
    .gate_a20_out(src), .drive_density_sel_0(src), .drive_density_sel_1(src),
    .power_event_out_n(src), .serial2_ring_indicate_n(ring_n), .dev_disable_wr_en(wr_en),
    .irq(irq));
  gpc_pad_model u_gpc_pad_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));
  function automatic logic [11:0] ca(input int i);
    return 12'(12'h0e4 + 4 * i);
  endfunction
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // address phase held until hready, then data phase held until hready again
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    int p;
    wt(4);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd_chk(ca(i), 32'h01);
      xfer(1'b1, ca(i), 32'hff);
      rd_chk(ca(i), (i == 3 || i > 4) ? 32'h8f : 32'h87);
    end
    rd_chk(12'h200, 32'h0);
    $display("test regs done");
    for (int k = 0; k < 8; k++) begin
      for (int i = 0; i < 5; i++)
        xfer(1'b1, ca(i), {24'h0, TCFG[k]});
      src <= TSRC[k];
      wt(3);
      chk(32'(pin_oe[4:0]), 32'(TOE[k]));
      chk(32'(pin_out[4:0] & pin_oe[4:0]), 32'(TOUT[k]));
    end
    gpo <= 7'h15;
    for (int i = 0; i < 5; i++)
      xfer(1'b1, ca(i), 32'h00);
    wt(3);
    chk(32'(pin_out[4:0]), 32'h15);
    for (int i = 0; i < 5; i++)
      xfer(1'b1, ca(i), 32'h02);
    wt(3);
    chk(32'(pin_out[4:0]), 32'h0a);
    chk(32'(hresp), 32'h0);
    $display("test drive done");
    ext_en <= 7'h7f;
    ext_val <= 7'h7f;
    xfer(1'b1, ca(3), 32'h09);
    xfer(1'b1, ca(5), 32'h0d);
    xfer(1'b1, 12'h104, 32'h3);
    for (int j = 0; j < 2; j++) begin
      p = j ? 5 : 3;
      ext_val[p] <= 1'b0;
      wt(6);
      chk(32'(irq), 32'h1);
      rd_chk(12'h100, 32'(1 << j));
      xfer(1'b1, 12'h100, 32'(1 << j));
      wt(2);
      chk(32'(irq), 32'h0);
      ext_val[p] <= 1'b1;
      wt(6);
      rd_chk(12'h100, 32'(1 << j));
      xfer(1'b1, 12'h100, 32'(1 << j));
    end
    // masked event still latches status but keeps the line low
    xfer(1'b1, 12'h104, 32'h0);
    ext_val[3] <= 1'b0;
    wt(6);
    chk(32'(irq), 32'h0);
    rd_chk(12'h100, 32'h1);
    $display("test edge done");
    xfer(1'b1, ca(5), 32'h06);
    wt(6);
    chk(32'(pin_oe[5]), 32'h0);
    chk(32'(pin_val[5]), 32'h1);
    chk(32'(wr_en), 32'h0);
    ext_val[5] <= 1'b0;
    wt(6);
    chk(32'(pin_val[5]), 32'h0);
    chk(32'(wr_en), 32'h1);
    xfer(1'b1, ca(5), 32'h0c);
    rd_chk(ca(5), 32'h04);
    hresetn <= 1'b0;
    wt(4);
    hresetn <= 1'b1;
    rd_chk(ca(5), 32'h01);
    $display("test lock done");
    xfer(1'b1, ca(6), 32'h05);
    for (int v = 0; v < 2; v++) begin
      ext_val[6] <= v[0];
      wt(6);
      chk(32'(ring_n), 32'(v));
    end
    ext_val[6] <= 1'b0;
    xfer(1'b1, ca(6), 32'h09);
    wt(6);
    chk(32'(ring_n), 32'h1);
    $display("test ring done");
    give_verdict();
  end
endmodule

// File: src/gpc_pin_group.sv
// seven-pin configuration group: config registers, pad drive, alternates, edge events
// assumes an ahb-lite master on hclk; pin inputs arrive asynchronously
//
// Summary of operation
// [R1] config bit 0: one makes the pin input, zero makes it output
// [R2] config bit 1: one inverts the pin value, zero passes it
// [R3] config bit 7: one gives open-drain, zero gives push-pull drive
// [R4] pin 3.6 bit 2 set routes active-low keyboard reset, clear keeps gpio
// [R5] pin 3.7 bit 2 set routes gate-a20, clear keeps gpio
// [R6] pin 4.0 bit 2 set routes drive density select 0
// [R7] pin 4.1 bits 3:2: 00 gpio, 01 density select 1, 10 edge interrupt 2
// [R8] pin 4.2 bit 2 set routes the power event signal
// [R9] power event output, non-inverted, drives active low with either driver type
// [R10] pin 4.3 bits 3:2: 11 edge interrupt 3, 01 write-protect control, 00 gpio
// [R11] write-protect control forces pin 4.3 to non-inverted input
// [R12] once pin 4.3 select is 01, writes cannot change it; only reset clears
// [R13] write-protect selected and pin high: device disable register is read-only
// [R14] write-protect selected and pin low: device disable register is writable
// [R15] pin 5.0 bits 3:2 01 routes serial port 2 ring indicate input
// [R16] reserved config bits read zero and ignore writes
// [R17] edge interrupt inputs flag every rising and falling synchronised transition
// [R18] reserved select codes leave the pin as plain gpio
//
// Decided for this implementation: the AHB-Lite slave port.
`include "gpc_regs.svh"

module gpc_pin_group
  import gpc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [6:0] pin_in,
  output logic [6:0] pin_out,
  output logic [6:0] pin_oe,
  output logic [6:0] pin_val,
  input wire logic [6:0] gpio_out_val,
  input wire logic keyboard_reset_out_n,
  input wire logic gate_a20_out,
  input wire logic drive_density_sel_0,
  input wire logic drive_density_sel_1,
  input wire logic power_event_out_n,
  output logic serial2_ring_indicate_n,
  output logic dev_disable_wr_en,
  output logic irq
);

  if (ADDR_W < 12) begin : g_chk
    $error("gpc_pin_group: ADDR_W must be at least 12");
  end

  gpc_state_t s_q;
  gpc_state_t s_d;

  logic [6:0] alt_en;
  logic [6:0] alt_val;
  logic [6:0] force_in;
  logic [6:0] nx_out;
  logic [6:0] nx_oe;
  logic [6:0] nx_val;
  logic wp_sel;
  logic ev2;
  logic ev3;
  logic [1:0] sel41;
  logic [1:0] sel43;
  logic [1:0] sel50;

  assign sel41 = s_q.cfg[3][3:2];
  assign sel43 = s_q.cfg[5][3:2];
  assign sel50 = s_q.cfg[6][3:2];
  assign wp_sel = (sel43 == `GPC_SEL_A); // [R10]

  // alternate output sources per pin; input-only codes add none, so an output pin keeps its gpio drive, except pin 4.3 with write-protect control, forced to input
  assign alt_en[0] = s_q.cfg[0][`GPC_BIT_ALT]; // [R4]
  assign alt_val[0] = keyboard_reset_out_n;
  assign alt_en[1] = s_q.cfg[1][`GPC_BIT_ALT]; // [R5]
  assign alt_val[1] = gate_a20_out;
  assign alt_en[2] = s_q.cfg[2][`GPC_BIT_ALT]; // [R6]
  assign alt_val[2] = drive_density_sel_0;
  assign alt_en[3] = (sel41 == `GPC_SEL_A); // [R7] [R18]
  assign alt_val[3] = drive_density_sel_1;
  // already active low at the source, so non-inverted keeps it low-true
  assign alt_en[4] = s_q.cfg[4][`GPC_BIT_ALT]; // [R8] [R9]
  assign alt_val[4] = power_event_out_n;
  assign alt_en[5] = 1'b0;
  assign alt_val[5] = 1'b0;
  assign alt_en[6] = 1'b0;
  assign alt_val[6] = 1'b0;
  assign force_in = {1'b0, wp_sel, 5'h00}; // [R11]

  for (genvar i = 0; i < 7; i++) begin : g_pad
    logic is_in;
    logic inv;
    logic lvl;
    assign is_in = s_q.cfg[i][`GPC_BIT_DIR] | force_in[i]; // [R1] [R11]
    assign inv = s_q.cfg[i][`GPC_BIT_POL] & ~force_in[i]; // [R2] [R11]
    assign lvl = (alt_en[i] ? alt_val[i] : gpio_out_val[i]) ^ inv;
    // open drain only ever pulls low; high is left to the board pull-up
    assign nx_oe[i] = ~is_in & (~s_q.cfg[i][`GPC_BIT_ODRN] | ~lvl); // [R3]
    assign nx_out[i] = ~is_in & lvl & ~s_q.cfg[i][`GPC_BIT_ODRN]; // [R3]
    assign nx_val[i] = s_q.sync2[i] ^ inv; // [R2]
  end

  // either edge of the synchronised level, only while the code is selected
  assign ev2 = (sel41 == `GPC_SEL_B) && (s_q.sync2[3] != s_q.prev[3]); // [R7] [R17]
  assign ev3 = (sel43 == `GPC_SEL_C) && (s_q.sync2[5] != s_q.prev[5]); // [R10] [R17]

  function automatic logic [31:0] rd_mux(input logic [9:0] idx, input gpc_state_t s);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (idx >= `GPC_IDX_FIRST && idx <= `GPC_IDX_P50) begin
      v = {24'h00_0000, s.cfg[3'(idx - `GPC_IDX_FIRST)]};
    end else if (idx == `GPC_IDX_STS) begin
      v = {30'h0000_0000, s.sts};
    end else if (idx == `GPC_IDX_MSK) begin
      v = {30'h0000_0000, s.msk};
    end else if (idx == `GPC_IDX_PINS) begin
      v = {24'h00_0000, s.dd_wr_ok, s.pval};
    end
    return v;
  endfunction

  function automatic logic [7:0] wmask(input logic [9:0] idx);
    logic [7:0] m;
    m = `GPC_WMASK_SEL1;
    if (idx == `GPC_IDX_P41 || idx == `GPC_IDX_P43 || idx == `GPC_IDX_P50) begin
      m = `GPC_WMASK_SEL2;
    end
    return m;
  endfunction

  always_comb begin
    logic addr_ok;
    logic take;
    logic [9:0] aidx;
    logic [2:0] ci;
    logic [7:0] m;
    logic [1:0] sts_c;
    addr_ok = 1'b0;
    take = 1'b0;
    aidx = 10'h000;
    ci = 3'h0;
    m = 8'h00;
    sts_c = s_q.sts;
    s_d = s_q;
    s_d.ready = 1'b1;
    // first stage feeds only the second
    s_d.sync1 = pin_in;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    s_d.pout = nx_out;
    s_d.poe = nx_oe;
    s_d.pval = nx_val;
    s_d.ri_n = (sel50 == `GPC_SEL_A) ? nx_val[6] : 1'b1; // [R15] [R18]
    s_d.dd_wr_ok = wp_sel ? ~s_q.sync2[5] : 1'b1; // [R13] [R14]

    // address phase: latch a write, answer a read in the next cycle
    addr_ok = (ADDR_W == 12) || ((haddr >> 12) == '0);
    take = hsel && htrans[1] && hready;
    aidx = addr_ok ? haddr[11:2] : 10'h3ff;
    s_d.wp.wr = take && hwrite;
    s_d.wp.idx = aidx;
    s_d.rdata = (take && !hwrite) ? rd_mux(aidx, s_q) : 32'h0000_0000;

    // data phase of a write
    if (s_q.wp.wr) begin
      if (s_q.wp.idx >= `GPC_IDX_FIRST && s_q.wp.idx <= `GPC_IDX_P50) begin
        ci = 3'(s_q.wp.idx - `GPC_IDX_FIRST);
        m = wmask(s_q.wp.idx);
        s_d.cfg[ci] = hwdata[7:0] & m; // [R16]
        // a selected write-protect control is frozen until reset
        if (s_q.wp.idx == `GPC_IDX_P43 && wp_sel) begin
          s_d.cfg[ci][3:2] = `GPC_SEL_A; // [R12]
        end
      end else if (s_q.wp.idx == `GPC_IDX_STS) begin
        sts_c = s_q.sts & ~hwdata[1:0];
      end else if (s_q.wp.idx == `GPC_IDX_MSK) begin
        s_d.msk = hwdata[1:0];
      end
    end
    // set wins over a simultaneous write-one-to-clear
    s_d.sts = sts_c | {ev3, ev2}; // [R17]
    s_d.irq = |(s_d.sts & s_d.msk);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.cfg <= {7{`GPC_CFG_RST}};
      s_q.ri_n <= 1'b1;
      s_q.dd_wr_ok <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.rdata;
  assign hreadyout = s_q.ready;
  assign hresp = 1'b0;
  assign pin_out = s_q.pout;
  assign pin_oe = s_q.poe;
  assign pin_val = s_q.pval;
  assign serial2_ring_indicate_n = s_q.ri_n;
  assign dev_disable_wr_en = s_q.dd_wr_ok;
  assign irq = s_q.irq;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_input_no_drive: assert property (s_q.cfg[1][0] |=> !pin_oe[1]) // [R1]
    else $error("input pin is driven");
  a_pol_invert: assert property (s_q.cfg[1] == 8'h02 |=> pin_out[1] == !$past(gpio_out_val[1])) // [R2]
    else $error("inverted output wrong");
  a_od_no_high: assert property (s_q.cfg[0][7] && !s_q.cfg[0][0] |=> !pin_out[0]) // [R3]
    else $error("open drain drives high");
  a_pp_drives: assert property (!s_q.cfg[2][7] && !s_q.cfg[2][0] |=> pin_oe[2]) // [R3]
    else $error("push pull not driven");
  a_kbd_route: assert property (s_q.cfg[0] == 8'h04 |=> pin_out[0] == $past(keyboard_reset_out_n)) // [R4]
    else $error("keyboard reset not routed");
  a_pme_low: assert property (s_q.cfg[4] == 8'h84 && !power_event_out_n |=> pin_oe[4] && !pin_out[4]) // [R9]
    else $error("power event not driven low");
  a_wp_lock: assert property (s_q.cfg[5][3:2] == 2'b01 |=> s_q.cfg[5][3:2] == 2'b01) // [R12]
    else $error("write-protect select changed");
  a_wp_input: assert property (s_q.cfg[5][3:2] == 2'b01 |=> !pin_oe[5]) // [R11]
    else $error("write-protect pin driven");
  a_ddr_ro: assert property (wp_sel && s_q.sync2[5] |=> !dev_disable_wr_en) // [R13]
    else $error("disable register writable while pin high");
  a_ddr_rw: assert property (wp_sel && !s_q.sync2[5] |=> dev_disable_wr_en) // [R14]
    else $error("disable register locked while pin low");
  a_ri_route: assert property (s_q.cfg[6] == 8'h05 |=> serial2_ring_indicate_n == $past(s_q.sync2[6])) // [R15]
    else $error("ring indicate not routed");
  a_rsvd_zero: assert property (s_q.cfg[0][6:3] == 4'h0 && s_q.cfg[6][6:4] == 3'h0) // [R16]
    else $error("reserved bits set");
  a_edge_flag: assert property (sel41 == 2'b10 && s_q.sync2[3] != s_q.prev[3] |=> s_q.sts[0] && (!s_q.msk[0] || irq)) // [R17]
    else $error("edge event lost");
  a_rsvd_gpio: assert property (s_q.cfg[3] == 8'h0c |=> pin_out[3] == $past(gpio_out_val[3])) // [R18]
    else $error("reserved code not plain gpio");

  // one check per routed function and per pad mode
  a_a20_route: assert property ( // [R5]
    s_q.cfg[1] == 8'h04 |=> pin_out[1] == $past(gate_a20_out))
    else $error("gate a20 not routed");

  a_dens0_route: assert property ( // [R6]
    s_q.cfg[2] == 8'h04 |=> pin_out[2] == $past(drive_density_sel_0))
    else $error("density select 0 not routed");

  a_dens1_route: assert property ( // [R7]
    s_q.cfg[3] == 8'h04 |=> pin_out[3] == $past(drive_density_sel_1))
    else $error("density select 1 not routed");

  a_pme_route: assert property ( // [R8]
    s_q.cfg[4] == 8'h04 |=> pin_out[4] == $past(power_event_out_n))
    else $error("power event not routed");

  a_pme_release: assert property ( // [R9]
    s_q.cfg[4] == 8'h84 && power_event_out_n |=> !pin_oe[4])
    else $error("idle power event still driven");

  a_edge3_flag: assert property ( // [R10]
    sel43 == 2'b11 && s_q.sync2[5] != s_q.prev[5] |=> s_q.sts[1])
    else $error("edge event 3 lost");

  a_sts_quiet: assert property ( // [R18]
    sel41 != 2'b10 && sel43 != 2'b11 && !s_q.wp.wr |=> s_q.sts == $past(s_q.sts))
    else $error("status changed without event");

  a_wp_val: assert property ( // [R11]
    sel43 == 2'b01 |=> pin_val[5] == $past(s_q.sync2[5]))
    else $error("write-protect pin inverted");

  a_wp_no_out: assert property ( // [R11]
    sel43 == 2'b01 |=> !pin_out[5])
    else $error("write-protect pin drives high");

  a_in_no_drive2: assert property ( // [R1]
    s_q.cfg[2][0] |=> !pin_oe[2])
    else $error("input pin 4.0 driven");

  a_out_drives: assert property ( // [R1]
    !s_q.cfg[0][0] && !s_q.cfg[0][7] |=> pin_oe[0])
    else $error("output pin 3.6 not driven");

  a_pol_val: assert property ( // [R2]
    s_q.cfg[2][1:0] == 2'b11 |=> pin_val[2] == !$past(s_q.sync2[2]))
    else $error("input inversion wrong");

  a_pol_pass: assert property ( // [R2]
    s_q.cfg[2][1:0] == 2'b01 |=> pin_val[2] == $past(s_q.sync2[2]))
    else $error("input passed inverted");

  a_val_plain: assert property ( // [R2]
    s_q.cfg[6][1:0] == 2'b01 |=> pin_val[6] == $past(s_q.sync2[6]))
    else $error("pin 5.0 value wrong");

  a_od_low: assert property ( // [R3]
    s_q.cfg[1][7] && s_q.cfg[1][2:0] == 3'b000 && !gpio_out_val[1] |=> pin_oe[1] && !pin_out[1])
    else $error("open drain does not pull low");

  a_od_release: assert property ( // [R3]
    s_q.cfg[1][7] && s_q.cfg[1][2:0] == 3'b000 && gpio_out_val[1] |=> !pin_oe[1])
    else $error("open drain drives high level");

  a_push_high: assert property ( // [R3]
    !s_q.cfg[2][7] && s_q.cfg[2][2:0] == 3'b000 && gpio_out_val[2] |=> pin_oe[2] && pin_out[2])
    else $error("push pull high missing");

  a_kbd_gpio: assert property ( // [R4]
    s_q.cfg[0] == 8'h00 |=> pin_out[0] == $past(gpio_out_val[0]))
    else $error("pin 3.6 gpio wrong");

  a_rsvd_sel1: assert property ( // [R16]
    s_q.cfg[1][6:3] == 4'h0 && s_q.cfg[2][6:3] == 4'h0 && s_q.cfg[4][6:3] == 4'h0)
    else $error("reserved bits set on single select");

  a_rsvd_sel2: assert property ( // [R16]
    s_q.cfg[3][6:4] == 3'h0 && s_q.cfg[5][6:4] == 3'h0)
    else $error("reserved bits set on double select");

  a_ri_idle: assert property ( // [R15]
    sel50 != 2'b01 |=> serial2_ring_indicate_n)
    else $error("ring indicate active while unselected");

  a_ddr_free: assert property ( // [R14]
    !wp_sel |=> dev_disable_wr_en)
    else $error("disable register locked without control");

  a_rsvd43_gpio: assert property ( // [R18]
    s_q.cfg[5] == 8'h08 |=> pin_out[5] == $past(gpio_out_val[5]))
    else $error("pin 4.3 reserved code not gpio");

  a_rsvd50_gpio: assert property ( // [R18]
    s_q.cfg[6] == 8'h0c |=> pin_out[6] == $past(gpio_out_val[6]))
    else $error("pin 5.0 reserved code not gpio");

  a_ready_high: assert property (
    1'b1 |=> hreadyout)
    else $error("wait state inserted");

  a_irq_level: assert property (
    irq == |(s_q.sts & s_q.msk))
    else $error("interrupt line disagrees with status");

  a_rdata_idle: assert property (
    !(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h0000_0000)
    else $error("read data without read");

  a_cfg_write: assert property ( // [R16]
    s_q.wp.wr && s_q.wp.idx == `GPC_IDX_P37 |=> s_q.cfg[1] == ($past(hwdata[7:0]) & 8'h87))
    else $error("config write lost");

  a_msk_write: assert property (
    s_q.wp.wr && s_q.wp.idx == `GPC_IDX_MSK |=> s_q.msk == $past(hwdata[1:0]))
    else $error("mask write lost");

  a_set_wins: assert property ( // [R17]
    ev2 |=> s_q.sts[0])
    else $error("clear beat a new event");

  c_cfg_write: cover property (s_q.wp.wr && s_q.wp.idx == `GPC_IDX_P37);
  c_edge_irq: cover property (ev2 ##1 irq);
  c_wp_locked: cover property (wp_sel ##1 s_q.wp.wr && s_q.wp.idx == `GPC_IDX_P43);
  c_ddr_toggle: cover property (dev_disable_wr_en ##[1:20] !dev_disable_wr_en);
  c_edge3_irq: cover property (ev3 ##1 irq);

endmodule

// File: src/gpc_pkg.sv
// types shared by the pin configuration group
// assumes gpc_regs.svh supplies the numeric constants
package gpc_pkg;
  typedef logic [7:0] gpc_cfg_t;

  typedef struct packed {
    logic wr;
    logic [9:0] idx;
  } gpc_bus_t;

  typedef struct packed {
    gpc_cfg_t [6:0] cfg;
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [6:0] prev;
    logic [1:0] sts;
    logic [1:0] msk;
    gpc_bus_t wp;
    logic [31:0] rdata;
    logic ready;
    logic [6:0] pout;
    logic [6:0] poe;
    logic [6:0] pval;
    logic ri_n;
    logic dd_wr_ok;
    logic irq;
  } gpc_state_t;
endpackage

// File: src/gpc_regs.svh
// register map, field positions and reset values of the pin configuration group
// assumes word-aligned 32-bit slave access; byte address = index * 4
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH

`define GPC_IDX_FIRST 10'h039
`define GPC_IDX_P36 10'h039
`define GPC_IDX_P37 10'h03a
`define GPC_IDX_P40 10'h03b
`define GPC_IDX_P41 10'h03c
`define GPC_IDX_P42 10'h03d
`define GPC_IDX_P43 10'h03e
`define GPC_IDX_P50 10'h03f
`define GPC_IDX_STS 10'h040
`define GPC_IDX_MSK 10'h041
`define GPC_IDX_PINS 10'h042

`define GPC_CFG_RST 8'h01
`define GPC_BIT_DIR 0
`define GPC_BIT_POL 1
`define GPC_BIT_ALT 2
`define GPC_BIT_ODRN 7
`define GPC_WMASK_SEL1 8'h87
`define GPC_WMASK_SEL2 8'h8f

`define GPC_SEL_GPIO 2'b00
`define GPC_SEL_A 2'b01
`define GPC_SEL_B 2'b10
`define GPC_SEL_C 2'b11

`endif
